/* rtl/dsau_top.sv */
`timescale 1ns/100ps
`include "dsau_defs.svh"
module dsau_top #(
  parameter int RAM_WORDS = `DSAU_RAM_WORDS,
  parameter logic [15:0] Y_BASE = `DSAU_Y_BASE
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic rd_word,
  input dsau_pkg::dsau_amode_t rd_mode,
  input wire logic [15:0] rd_ptr,
  input wire logic [15:0] rd_abs,
  input wire logic [7:0] read_page_select,
  input wire logic [7:0] rd_wreg_hi,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic [15:0] rd_wreg,
  output logic [15:0] rd_ptr_next,
  output logic [23:0] rd_ext_addr,
  input wire logic y_rd_req,
  input wire logic [15:0] y_ptr,
  output logic y_rd_valid,
  output logic [15:0] y_rd_data,
  output logic [15:0] y_ptr_next,
  input wire logic wr_req,
  input wire logic wr_word,
  input dsau_pkg::dsau_amode_t wr_mode,
  input wire logic [15:0] wr_ptr,
  input wire logic [15:0] wr_abs,
  input wire logic [7:0] write_page_select,
  input wire logic [15:0] wr_data,
  output logic [15:0] wr_ptr_next,
  output logic [23:0] wr_ext_addr,
  input wire logic x_mod_en,
  input wire logic [15:0] x_mod_start,
  input wire logic [15:0] x_mod_end,
  input wire logic y_mod_en,
  input wire logic [15:0] y_mod_start,
  input wire logic [15:0] y_mod_end,
  input wire logic brev_en,
  input wire logic [15:0] brev_mod,
  output logic sfr_rd_en,
  output logic [15:0] sfr_rd_addr,
  input wire logic [15:0] sfr_rdata,
  input wire logic sfr_hit,
  output logic sfr_wr_en,
  output logic [15:0] sfr_wr_addr,
  output logic [1:0] sfr_wr_be,
  output logic [15:0] sfr_wdata,
  output logic addr_err_trap,
  output logic addr_err_write
);
  import dsau_pkg::*;

  localparam int IDXW = $clog2(RAM_WORDS);
  localparam logic [16:0] RAM_LO = {1'b0, `DSAU_RAM_BASE};
  localparam logic [16:0] RAM_HI = 17'(`DSAU_RAM_BASE) + 17'(2 * RAM_WORDS);

  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // three address generators: X read, write, Y read
  logic [15:0] x_ea;
  logic [15:0] w_ea;
  logic [15:0] y_ea;
  logic [15:0] x_next;
  logic [15:0] w_next;
  logic [15:0] y_next;

  dsau_agu #(.BITREV_EN(1'b0)) u_agu_rd (
    .mode(rd_mode), .ptr(rd_ptr), .abs_addr(rd_abs), .word(rd_word),
    .mod_en(x_mod_en), .mod_start(x_mod_start), .mod_end(x_mod_end),
    .brev_en(1'b0), .brev_mod(16'h0000), .ea(x_ea), .ptr_next(x_next)
  );

  dsau_agu #(.BITREV_EN(1'b1)) u_agu_wr (
    .mode(wr_mode), .ptr(wr_ptr), .abs_addr(wr_abs), .word(wr_word),
    .mod_en(x_mod_en), .mod_start(x_mod_start), .mod_end(x_mod_end),
    .brev_en(brev_en), .brev_mod(brev_mod), .ea(w_ea), .ptr_next(w_next)
  );

  dsau_agu #(.BITREV_EN(1'b0)) u_agu_y (
    .mode(DSAU_AM_IND), .ptr(y_ptr), .abs_addr(16'h0000), .word(1'b1),
    .mod_en(y_mod_en), .mod_start(y_mod_start), .mod_end(y_mod_end),
    .brev_en(1'b0), .brev_mod(16'h0000), .ea(y_ea), .ptr_next(y_next)
  );

  dsau_lane_if #(.IDXW(IDXW)) lo_if ();
  dsau_lane_if #(.IDXW(IDXW)) hi_if ();

  dsau_lane #(.WORDS(RAM_WORDS)) u_lane_lo (.sys_clk(sys_clk), .lp(lo_if.lane));
  dsau_lane #(.WORDS(RAM_WORDS)) u_lane_hi (.sys_clk(sys_clk), .lp(hi_if.lane));

  // address decode; a non-zero page lies in extended space, not implemented here
  logic x_base;
  logic w_base;
  logic x_sfr;
  logic w_sfr;
  logic x_ram;
  logic w_ram;
  logic y_ram;
  logic [15:0] x_off;
  logic [15:0] w_off;
  logic [15:0] y_off;
  logic x_err;
  logic w_err;
  logic y_err;

  assign x_base = (read_page_select == 8'h00);
  assign w_base = (write_page_select == 8'h00);
  assign x_sfr = x_base && (x_ea <= `DSAU_SFR_LAST);
  assign w_sfr = w_base && (w_ea <= `DSAU_SFR_LAST);
  assign x_ram = x_base && ({1'b0, x_ea} >= RAM_LO) && ({1'b0, x_ea} < RAM_HI);
  assign w_ram = w_base && ({1'b0, w_ea} >= RAM_LO) && ({1'b0, w_ea} < RAM_HI);
  assign y_ram = (y_ea >= Y_BASE) && ({1'b0, y_ea} < RAM_HI);
  assign x_off = x_ea - `DSAU_RAM_BASE;
  assign w_off = w_ea - `DSAU_RAM_BASE;
  assign y_off = y_ea - `DSAU_RAM_BASE;

  assign x_err = rd_req && rd_word && x_ea[0];
  assign w_err = wr_req && wr_word && w_ea[0];
  assign y_err = y_rd_req && y_ea[0];

  // lane strobes: shared index, lane chosen by byte address
  logic w_lo_sel;
  logic w_hi_sel;

  assign w_lo_sel = wr_word || !w_ea[0];
  assign w_hi_sel = wr_word || w_ea[0];

  always_comb begin
    lo_if.wr_idx = w_off[IDXW:1];
    hi_if.wr_idx = w_off[IDXW:1];
    lo_if.wr_en = wr_req && w_ram && !w_err && w_lo_sel;
    hi_if.wr_en = wr_req && w_ram && !w_err && w_hi_sel;
    lo_if.wr_byte = wr_data[7:0];
    hi_if.wr_byte = wr_word ? wr_data[15:8] : wr_data[7:0];
    lo_if.x_idx = x_off[IDXW:1];
    hi_if.x_idx = x_off[IDXW:1];
    lo_if.y_idx = y_off[IDXW:1];
    hi_if.y_idx = y_off[IDXW:1];
  end

  // register space port
  assign sfr_rd_en = rd_req && x_sfr;
  assign sfr_rd_addr = {x_ea[15:1], 1'b0};
  assign sfr_wr_en = wr_req && w_sfr && !w_err;
  assign sfr_wr_addr = {w_ea[15:1], 1'b0};
  assign sfr_wr_be = {w_hi_sel, w_lo_sel};
  assign sfr_wdata = {hi_if.wr_byte, lo_if.wr_byte};

  // X read path
  logic [15:0] x_word;
  logic [7:0] x_byte;

  always_comb begin
    if (x_ram) begin
      x_word = {hi_if.x_byte, lo_if.x_byte};
    end else if (x_sfr && sfr_hit) begin
      x_word = sfr_rdata;
    end else begin
      x_word = 16'h0000;
    end
    x_byte = x_ea[0] ? x_word[15:8] : x_word[7:0];
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      rd_wreg <= 16'h0000;
      rd_ptr_next <= 16'h0000;
      rd_ext_addr <= 24'h000000;
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        rd_data <= rd_word ? (x_err ? 16'h0000 : x_word) : {8'h00, x_byte};
        rd_wreg <= rd_word ? (x_err ? 16'h0000 : x_word) : {rd_wreg_hi, x_byte};
        rd_ptr_next <= x_next;
        rd_ext_addr <= {read_page_select, x_ea};
      end
    end
  end

  // Y read path
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      y_rd_valid <= 1'b0;
      y_rd_data <= 16'h0000;
      y_ptr_next <= 16'h0000;
    end else begin
      y_rd_valid <= y_rd_req;
      if (y_rd_req) begin
        y_rd_data <= (y_ram && !y_err) ? {hi_if.y_byte, lo_if.y_byte} : 16'h0000;
        y_ptr_next <= y_next;
      end
    end
  end

  // write side results
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ptr_next <= 16'h0000;
      wr_ext_addr <= 24'h000000;
    end else if (wr_req) begin
      wr_ptr_next <= w_next;
      wr_ext_addr <= {write_page_select, w_ea};
    end
  end

  // address error trap, one cycle after the faulting access
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      addr_err_trap <= 1'b0;
      addr_err_write <= 1'b0;
    end else begin
      addr_err_trap <= x_err || w_err || y_err;
      addr_err_write <= w_err;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_n);

  chk_misread_trap: assert property (x_err |=> addr_err_trap && rd_valid)
    else $error("misaligned read did not trap");
  chk_miswrite_block: assert property (w_err |->
    !lo_if.wr_en && !hi_if.wr_en && !sfr_wr_en ##1 addr_err_trap && addr_err_write)
    else $error("misaligned write not suppressed");
  chk_trap_cause: assert property (addr_err_trap |-> $past(x_err || w_err || y_err))
    else $error("trap without cause");
  chk_trap_single: assert property (addr_err_trap && !x_err && !w_err && !y_err |=>
    !addr_err_trap)
    else $error("trap longer than one cycle");
  chk_y_misread: assert property (y_err && !w_err |=>
    addr_err_trap && !addr_err_write && y_rd_data == 16'h0000)
    else $error("misaligned Y read not trapped");
  chk_byte_lane: assert property (wr_req && !wr_word && !w_ea[0] |-> !hi_if.wr_en)
    else $error("even byte write hit high lane");
  chk_odd_byte_lane: assert property (wr_req && !wr_word && w_ea[0] |-> !lo_if.wr_en)
    else $error("odd byte write hit low lane");
  chk_word_lanes: assert property (wr_req && wr_word && w_ram && !w_err |->
    lo_if.wr_en && hi_if.wr_en && hi_if.wr_byte == wr_data[15:8])
    else $error("word write missed a lane");
  chk_page_drop: assert property (wr_req && !w_base |->
    !lo_if.wr_en && !hi_if.wr_en && !sfr_wr_en)
    else $error("write outside base page performed");
  chk_y_bound_zero: assert property (y_rd_req && !y_ram |=> y_rd_data == 16'h0000)
    else $error("Y read outside Y space not zero");
  chk_wr_ext_page: assert property (wr_req |=>
    wr_ext_addr == {$past(write_page_select), $past(w_ea)})
    else $error("write extended address wrong");
  chk_byte_read_low: assert property (rd_req && !rd_word |=> rd_data[15:8] == 8'h00)
    else $error("byte read not on low lane");
  chk_unimpl_zero: assert property (rd_req && !x_ram && !x_sfr |=> rd_data == 16'h0000)
    else $error("unimplemented read not zero");
  chk_sfr_zero: assert property (rd_req && x_sfr && !sfr_hit |=> rd_data == 16'h0000)
    else $error("unused register read not zero");
  chk_wreg_high_kept: assert property (rd_req && !rd_word |=>
    rd_wreg[15:8] == $past(rd_wreg_hi))
    else $error("byte load altered high byte");
  chk_postinc_step: assert property (rd_req && !x_mod_en |=>
    rd_ptr_next == 16'($past(rd_ptr) + ($past(rd_word) ? 16'h0002 : 16'h0001)))
    else $error("post increment step wrong");
  chk_ext_page: assert property (rd_req |=>
    rd_ext_addr == {$past(read_page_select), $past(x_ea)})
    else $error("extended address wrong");

  cov_miswrite: cover property (w_err ##1 addr_err_trap);
  cov_dual_read: cover property (rd_req && y_rd_req && x_ram && y_ram);
  cov_odd_byte_write: cover property (wr_req && !wr_word && w_ea[0] && hi_if.wr_en);
  cov_sfr_read: cover property (rd_req && x_sfr && sfr_hit);
  cov_y_wrap: cover property (y_rd_req && y_mod_en && y_next == y_mod_start);
endmodule // dsau_top

/* rtl/dsau_defs.svh */
`ifndef DSAU_DEFS_SVH
`define DSAU_DEFS_SVH

// effective address and page widths
`define DSAU_EA_W 16
`define DSAU_PAGE_W 8
`define DSAU_NEAR_W 13

// memory map
`define DSAU_SFR_LAST 16'h0FFF
`define DSAU_RAM_BASE 16'h1000
`define DSAU_NEAR_LAST 16'h1FFF
`define DSAU_RAM_WORDS 24576
`define DSAU_Y_BASE 16'h9000

// post-modify steps
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002

`endif

/* rtl/dsau_pkg.sv */
package dsau_pkg;

  typedef enum logic [2:0] {
    DSAU_AM_IND   = 3'b001,
    DSAU_AM_NEAR  = 3'b010,
    DSAU_AM_DIR16 = 3'b100
  } dsau_amode_t;

endpackage

/* rtl/dsau_lane_if.sv */
`timescale 1ns/100ps
interface dsau_lane_if #(parameter int IDXW = 15);
  logic [IDXW-1:0] wr_idx;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [IDXW-1:0] x_idx;
  logic [7:0] x_byte;
  logic [IDXW-1:0] y_idx;
  logic [7:0] y_byte;

  modport lane (input wr_idx, input wr_en, input wr_byte, input x_idx, input y_idx,
                output x_byte, output y_byte);
  modport ctrl (output wr_idx, output wr_en, output wr_byte, output x_idx, output y_idx,
                input x_byte, input y_byte);
endinterface

/* rtl/dsau_lane.sv */
`timescale 1ns/100ps
module dsau_lane #(
  parameter int WORDS = 24576
) (
  input wire logic sys_clk,
  dsau_lane_if.lane lp
);
  logic [7:0] mem_q [WORDS];

  // one byte lane; shared word index, its own write strobe
  always_ff @(posedge sys_clk) begin
    if (lp.wr_en) begin
      mem_q[lp.wr_idx] <= lp.wr_byte;
    end
  end

  assign lp.x_byte = mem_q[lp.x_idx];
  assign lp.y_byte = mem_q[lp.y_idx];
endmodule // dsau_lane

/* rtl/dsau_agu.sv */
`timescale 1ns/100ps
`include "dsau_defs.svh"
module dsau_agu #(
  parameter bit BITREV_EN = 1'b0
) (
  input dsau_pkg::dsau_amode_t mode,
  input wire logic [15:0] ptr,
  input wire logic [15:0] abs_addr,
  input wire logic word,
  input wire logic mod_en,
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  input wire logic brev_en,
  input wire logic [15:0] brev_mod,
  output logic [15:0] ea,
  output logic [15:0] ptr_next
);
  import dsau_pkg::*;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction

  logic [15:0] step;
  logic [15:0] inc;

  always_comb begin
    unique case (mode)
      DSAU_AM_IND: ea = ptr;
      DSAU_AM_NEAR: ea = {3'h0, abs_addr[`DSAU_NEAR_W-1:0]};
      DSAU_AM_DIR16: ea = abs_addr;
      default: ea = 16'h0000;
    endcase
  end

  always_comb begin
    step = word ? `DSAU_STEP_WORD : `DSAU_STEP_BYTE;
    inc = ptr + step;
    if (BITREV_EN && brev_en && word) begin
      ptr_next = rev16(rev16(ptr) + rev16(brev_mod));
    end else if (mod_en && (ptr <= mod_end) && (inc > mod_end)) begin
      ptr_next = mod_start;
    end else begin
      ptr_next = inc;
    end
  end
endmodule // dsau_agu

/* verif/dsau_sfr_model.sv */
`timescale 1ns/100ps
module dsau_sfr_model (
  input wire logic sys_clk,
  input wire logic [15:0] sfr_rd_addr,
  output logic [15:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic sfr_wr_en,
  input wire logic [15:0] sfr_wr_addr,
  input wire logic [1:0] sfr_wr_be,
  input wire logic [15:0] sfr_wdata
);
  logic [15:0] regs [64];
  logic wr_hit;
  // only 0x0100-0x017F is populated; elsewhere the bus floats to a junk pattern
  assign sfr_hit = (sfr_rd_addr[15:7] == 9'h002);
  assign sfr_rdata = sfr_hit ? regs[sfr_rd_addr[6:1]] : 16'hA5C3;
  assign wr_hit = sfr_wr_en && (sfr_wr_addr[15:7] == 9'h002);
  initial begin
    for (int i = 0; i < 64; i++) begin
      regs[i] = {8'hC0, 8'(i)};
    end
  end
  always @(posedge sys_clk) begin
    if (wr_hit && sfr_wr_be[0]) regs[sfr_wr_addr[6:1]][7:0] <= sfr_wdata[7:0];
    if (wr_hit && sfr_wr_be[1]) regs[sfr_wr_addr[6:1]][15:8] <= sfr_wdata[15:8];
  end
endmodule // dsau_sfr_model

/* verif/test_data_space_access_unit.sv */
`timescale 1ns/100ps
module test_data_space_access_unit;
  import dsau_pkg::*;
  logic sys_clk = 0, rst_n = 0, rd_req = 0, rd_word = 0, y_rd_req = 0, wr_req = 0, wr_word = 0;
  dsau_amode_t rd_mode = DSAU_AM_IND, wr_mode = DSAU_AM_IND;
  logic [15:0] rd_ptr = 0, rd_abs = 0, y_ptr = 0, wr_ptr = 0, wr_abs = 0, wr_data = 0;
  logic [15:0] x_mod_start = 0, x_mod_end = 0, brev_mod = 0, y_mod_start = 0, y_mod_end = 0;
  logic [7:0] read_page_select = 0, write_page_select = 0, rd_wreg_hi = 0;
  logic x_mod_en = 0, brev_en = 0, y_mod_en = 0;
  logic rd_valid, y_rd_valid, addr_err_trap, addr_err_write, sfr_rd_en, sfr_hit, sfr_wr_en;
  logic [15:0] rd_data, rd_wreg, rd_ptr_next, y_rd_data, y_ptr_next, wr_ptr_next;
  logic [15:0] sfr_rd_addr, sfr_rdata, sfr_wr_addr, sfr_wdata;
  logic [23:0] rd_ext_addr, wr_ext_addr;
  logic [1:0] sfr_wr_be;
  int err_total = 0, checks_done = 0;
  int sfr_reads = 0, sfr_writes = 0;

  dsau_top #(.RAM_WORDS(256), .Y_BASE(16'h1100)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .rd_req(rd_req), .rd_word(rd_word), .rd_mode(rd_mode), .rd_ptr(rd_ptr), .rd_abs(rd_abs),
    .read_page_select(read_page_select), .rd_wreg_hi(rd_wreg_hi), .rd_valid(rd_valid),
    .rd_data(rd_data), .rd_wreg(rd_wreg), .rd_ptr_next(rd_ptr_next), .rd_ext_addr(rd_ext_addr),
    .y_rd_req(y_rd_req), .y_ptr(y_ptr), .y_rd_valid(y_rd_valid), .y_rd_data(y_rd_data),
    .y_ptr_next(y_ptr_next), .wr_req(wr_req), .wr_word(wr_word), .wr_mode(wr_mode),
    .wr_ptr(wr_ptr), .wr_abs(wr_abs), .write_page_select(write_page_select),
    .wr_data(wr_data), .wr_ptr_next(wr_ptr_next), .wr_ext_addr(wr_ext_addr),
    .x_mod_en(x_mod_en), .x_mod_start(x_mod_start), .x_mod_end(x_mod_end),
    .y_mod_en(y_mod_en), .y_mod_start(y_mod_start), .y_mod_end(y_mod_end), .brev_en(brev_en),
    .brev_mod(brev_mod), .sfr_rd_en(sfr_rd_en), .sfr_rd_addr(sfr_rd_addr),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sfr_wr_en(sfr_wr_en),
    .sfr_wr_addr(sfr_wr_addr), .sfr_wr_be(sfr_wr_be), .sfr_wdata(sfr_wdata),
    .addr_err_trap(addr_err_trap), .addr_err_write(addr_err_write));

  dsau_sfr_model far_side (.sys_clk(sys_clk), .sfr_rd_addr(sfr_rd_addr),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sfr_wr_en(sfr_wr_en),
    .sfr_wr_addr(sfr_wr_addr), .sfr_wr_be(sfr_wr_be), .sfr_wdata(sfr_wdata));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // register-space strobes seen at the far side
  always @(posedge sys_clk) begin
    if (sfr_rd_en) sfr_reads <= sfr_reads + 1;
    if (sfr_wr_en) sfr_writes <= sfr_writes + 1;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one access, answer judged one cycle later, trap pulse gone the cycle after
  task automatic rd(input logic w, input dsau_amode_t m, input logic [15:0] a,
                    input logic [7:0] pg, input logic t);
    rd_req = 1;
    rd_word = w;
    rd_mode = m;
    rd_ptr = a;
    rd_abs = a;
    read_page_select = pg;
    @(negedge sys_clk);
    rd_req = 0;
    check(rd_valid, 1'b1);
    check({addr_err_trap, addr_err_trap & addr_err_write}, {t, 1'b0});
    @(negedge sys_clk);
    check(addr_err_trap, 1'b0);
  endtask

  task automatic wr(input logic w, input logic [15:0] a, input logic [15:0] d,
                    input logic t);
    wr_req = 1;
    wr_word = w;
    wr_ptr = a;
    wr_abs = a;
    wr_data = d;
    @(negedge sys_clk);
    wr_req = 0;
    check({addr_err_trap, addr_err_trap & addr_err_write}, {t, t});
    @(negedge sys_clk);
    check(addr_err_trap, 1'b0);
  endtask

  task automatic ram_lanes;
    wr(1, 16'h1000, 16'hBEEF, 0);
    check(wr_ptr_next, 16'h1002);
    check(wr_ext_addr, 24'h001000);
    wr(1, 16'h1002, 16'h3344, 0);
    wr(0, 16'h1003, 16'h00AA, 0);
    check(wr_ptr_next, 16'h1004);
    rd(1, DSAU_AM_IND, 16'h1002, 0, 0);
    check(rd_data, 16'hAA44);
    check(rd_ptr_next, 16'h1004);
    rd_wreg_hi = 8'h77;
    rd(0, DSAU_AM_IND, 16'h1003, 0, 0);
    check(rd_data, 16'h00AA);
    check(rd_wreg, 16'h77AA);
    check(rd_ptr_next, 16'h1004);
    rd(0, DSAU_AM_IND, 16'h1000, 0, 0);
    check(rd_data, 16'h00EF);
    rd(0, DSAU_AM_IND, 16'h1001, 0, 0);
    check(rd_data, 16'h00BE);
  endtask

  task automatic misalign;
    wr(1, 16'h1004, 16'h5566, 0);
    wr(1, 16'h1005, 16'hFFFF, 1);
    rd(1, DSAU_AM_IND, 16'h1004, 0, 0);
    check(rd_data, 16'h5566);
    rd(1, DSAU_AM_IND, 16'h1005, 0, 1);
    check(rd_data, 16'h0000);
  endtask

  task automatic space_map;
    rd(1, DSAU_AM_IND, 16'h1200, 0, 0);
    check(rd_data, 16'h0000);
    rd(1, DSAU_AM_DIR16, 16'h0102, 0, 0);
    check(rd_data, 16'hC001);
    rd(1, DSAU_AM_NEAR, 16'hE102, 0, 0);
    check(rd_data, 16'hC001);
    check(rd_ext_addr, 24'h000102);
    rd(1, DSAU_AM_DIR16, 16'h0200, 0, 0);
    check(rd_data, 16'h0000);
    wr_mode = DSAU_AM_NEAR;
    wr(1, 16'hE104, 16'h1234, 0);
    check(wr_ext_addr, 24'h000104);
    wr_mode = DSAU_AM_IND;
    rd(1, DSAU_AM_IND, 16'h0104, 0, 0);
    check(rd_data, 16'h1234);
    wr(0, 16'h0105, 16'h0055, 0);
    wr(1, 16'h0107, 16'hFFFF, 1);
    rd(1, DSAU_AM_IND, 16'h0104, 0, 0);
    check(rd_data, 16'h5534);
    rd(1, DSAU_AM_IND, 16'h0106, 0, 0);
    check(rd_data, 16'hC003);
    check(24'(sfr_reads), 24'h000006);
    check(24'(sfr_writes), 24'h000002);
    rd(1, DSAU_AM_IND, 16'h1000, 8'h01, 0);
    check(rd_data, 16'h0000);
    check(rd_ext_addr, 24'h011000);
    write_page_select = 8'h01;
    wr(1, 16'h1000, 16'h0BAD, 0);
    check(wr_ext_addr, 24'h011000);
    write_page_select = 8'h00;
  endtask

  task automatic xy_paths;
    wr(1, 16'h1100, 16'hCAFE, 0);
    rd_req = 1;
    rd_word = 1;
    rd_mode = DSAU_AM_IND;
    rd_ptr = 16'h1000;
    read_page_select = 0;
    y_rd_req = 1;
    y_ptr = 16'h1100;
    @(negedge sys_clk);
    rd_req = 0;
    check(rd_data, 16'hBEEF);
    check({y_rd_valid, y_rd_data}, {1'b1, 16'hCAFE});
    check(y_ptr_next, 16'h1102);
    y_mod_en = 1;
    y_mod_start = 16'h1000;
    y_mod_end = 16'h1001;
    y_ptr = 16'h1000;
    @(negedge sys_clk);
    check(y_ptr_next, 16'h1000);
    check(y_rd_data, 16'h0000);
    y_mod_en = 0;
    y_ptr = 16'h1101;
    @(negedge sys_clk);
    y_rd_req = 0;
    check({y_rd_valid, y_rd_data}, {1'b1, 16'h0000});
    check({addr_err_trap, addr_err_write}, 2'b10);
    @(negedge sys_clk);
    check(addr_err_trap, 1'b0);
  endtask

  task automatic addr_modes;
    x_mod_en = 1;
    x_mod_start = 16'h1000;
    x_mod_end = 16'h1003;
    rd(1, DSAU_AM_IND, 16'h1002, 0, 0);
    check(rd_ptr_next, 16'h1000);
    x_mod_en = 0;
    brev_en = 1;
    brev_mod = 16'h0008;
    wr(1, 16'h1008, 16'h0001, 0);
    check(wr_ptr_next, 16'h1004);
    wr(0, 16'h1008, 16'h0002, 0);
    check(wr_ptr_next, 16'h1009);
    rd(1, DSAU_AM_IND, 16'h1008, 0, 0);
    check(rd_ptr_next, 16'h100A);
    brev_en = 0;
  endtask

  initial begin
    #200000;
    err_total++;
    end_of_test;
  end

  initial begin
    repeat (6) @(negedge sys_clk);
    check({rd_valid, addr_err_trap}, 2'b00);
    rst_n = 1;
    repeat (3) @(negedge sys_clk);
    ram_lanes;
    misalign;
    space_map;
    xy_paths;
    addr_modes;
    end_of_test;
  end
endmodule // test_data_space_access_unit
